// ==== hw/qpd_pkg.sv ====
// Shared constants and types for the quad potentiometer serial command decoder.
package qpd_pkg;
  // Device type prefix in the first six bits of every frame (arbitrary value).
  localparam logic [5:0] QPD_TYPE_PREFIX = 6'h2a;
  // Instruction nibbles.
  localparam logic [3:0] QPD_OP_RD_WIPER = 4'h9;
  localparam logic [3:0] QPD_OP_WR_WIPER = 4'ha;
  localparam logic [3:0] QPD_OP_RD_SLOT = 4'hb;
  localparam logic [3:0] QPD_OP_WR_SLOT = 4'hc;
  localparam logic [3:0] QPD_OP_RECALL = 4'hd;
  localparam logic [3:0] QPD_OP_STORE = 4'he;
  localparam logic [3:0] QPD_OP_GRECALL = 4'h1;
  localparam logic [3:0] QPD_OP_GSTORE = 4'h8;
  localparam logic [3:0] QPD_OP_STEP = 4'h2;
  localparam logic [3:0] QPD_OP_STATUS = 4'h5;
  localparam logic [3:0] QPD_STATUS_LOW = 4'h1;
  // Bit counts inside a frame.
  localparam logic [4:0] QPD_ADDR_BITS = 5'h08;
  localparam logic [4:0] QPD_CMD_BITS = 5'h10;
  localparam logic [4:0] QPD_DATA_BITS = 5'h18;
  // Nonvolatile write time in microseconds, and cycles at 4 ns.
  localparam int QPD_NV_WRITE_US = 5000;
  localparam int QPD_CLK_NS = 4;
  localparam int QPD_NV_WRITE_CYC = QPD_NV_WRITE_US * 1000 / QPD_CLK_NS;
  // Reset values and wiper limits.
  localparam logic [7:0] QPD_WIPER_RST = 8'h80;
  localparam logic [7:0] QPD_SLOT_RST = 8'h80;
  localparam logic [7:0] QPD_WIPER_MAX = 8'hff;
  localparam logic [7:0] QPD_WIPER_MIN = 8'h00;
  typedef enum {QPD_IDLE, QPD_ADDR, QPD_CMD, QPD_DATA, QPD_STEP, QPD_SKIP} qpd_state_t;
endpackage

// ==== hw/qpd_sync.sv ====
// Two-stage synchroniser for a group of pin inputs.
`timescale 1ns/1ps
`default_nettype none
module qpd_sync #(
  parameter int WIDTH = 3
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } qpd_sync_st_t;
  qpd_sync_st_t s_q, s_d;
  // The first stage feeds only the second stage.
  always_comb begin
    s_d = s_q;
    s_d.meta = async_in;
    s_d.sync = s_q.meta;
  end
  // Reset parks chip select high so no frame starts during reset.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s_q <= '{meta: {WIDTH{1'b1}}, sync: {WIDTH{1'b1}}};
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end
  assign sync_out = s_q.sync;
endmodule
`default_nettype wire

// ==== hw/qpd_decoder.sv ====
// Serial command decoder for a four-channel digital potentiometer.
`timescale 1ns/1ps
`default_nettype none
module qpd_decoder #(
  parameter int NV_WRITE_CYC = qpd_pkg::QPD_NV_WRITE_CYC
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic strap_addr_hi,
  input wire logic strap_addr_lo,
  output logic so,
  output logic so_oe,
  output logic nv_write_pending_flag,
  output logic [31:0] wiper_position_reg
);
  import qpd_pkg::*;

  typedef enum {QPD_NV_NONE, QPD_NV_ONE, QPD_NV_ALL} qpd_nv_t;
  typedef struct packed {
    qpd_state_t st;
    logic sck_prev;
    logic [4:0] cnt;
    logic [15:0] shreg;
    logic [7:0] tx;
    logic so;
    logic so_oe;
    logic [1:0] nv_kind;
    logic [1:0] nv_ch;
    logic [1:0] nv_slot;
    logic [7:0] nv_data;
    logic [31:0] nv_cnt;
    logic busy;
    logic [3:0][7:0] wiper;
    logic [3:0][3:0][7:0] slot;
  } qpd_state_st_t;

  qpd_state_st_t s_q, s_d;
  logic [4:0] pins;
  logic sck_s, cs_s, si_s, strap_hi_s, strap_lo_s, rise, fall;

  // Pins cross into the core clock through two flops.
  // The straps are pins as well; they settle long before any address byte completes.
  qpd_sync #(.WIDTH(5)) u_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .async_in({sck, cs_n, si, strap_addr_hi, strap_addr_lo}),
    .sync_out(pins)
  );
  assign sck_s = pins[4];
  assign cs_s = pins[3];
  assign si_s = pins[2];
  assign strap_hi_s = pins[1];
  assign strap_lo_s = pins[0];
  assign rise = sck_s && !s_q.sck_prev;
  assign fall = !sck_s && s_q.sck_prev;

  // Decides whether an opcode byte needs a data byte after it.
  function automatic logic has_data(input logic [3:0] op);
    return op == QPD_OP_RD_WIPER || op == QPD_OP_WR_WIPER || op == QPD_OP_RD_SLOT ||
           op == QPD_OP_WR_SLOT || op == QPD_OP_STATUS;
  endfunction

  // Frame engine: bits are taken on SCK rise, read data changes on SCK fall.
  always_comb begin
    logic [15:0] sh;
    logic [3:0] op;
    logic [1:0] rs, ch;
    sh = {s_q.shreg[14:0], si_s};
    op = s_q.shreg[7:4];
    rs = s_q.shreg[3:2];
    ch = s_q.shreg[1:0];
    s_d = s_q;
    s_d.sck_prev = sck_s;
    // The write timer runs on; a store started mid-cycle waits for it.
    if (s_q.busy) begin
      if (s_q.nv_cnt == 32'(NV_WRITE_CYC - 1)) begin
        s_d.busy = 1'b0;
      end else begin
        s_d.nv_cnt = s_q.nv_cnt + 32'h1;
      end
    end
    if (cs_s) begin
      // Chip select high ends the frame; only complete stores commit here.
      if (s_q.nv_kind != 2'(QPD_NV_NONE) && !s_q.busy) begin
        if (s_q.nv_kind == 2'(QPD_NV_ALL)) begin
          for (int c = 0; c < 4; c++) begin
            s_d.slot[c][s_q.nv_slot] = s_q.wiper[c];
          end
        end else begin
          s_d.slot[s_q.nv_ch][s_q.nv_slot] = s_q.nv_data;
        end
        s_d.busy = 1'b1;
        s_d.nv_cnt = 32'h0;
        s_d.nv_kind = 2'(QPD_NV_NONE);
      end
      // A cut frame never arms a store; one still waiting on the timer stays armed, but a cut past the command byte rewrites its nv_ch and nv_slot.
      s_d.st = QPD_IDLE;
      s_d.so_oe = 1'b0;
      s_d.cnt = 5'h0;
    end else begin
      case (s_q.st)
        QPD_IDLE: begin
          s_d.st = QPD_ADDR;
          s_d.cnt = 5'h0;
        end
        QPD_ADDR, QPD_CMD, QPD_DATA: begin
          if (rise) begin
            s_d.shreg = sh;
            s_d.cnt = s_q.cnt + 5'h1;
            if (s_d.cnt == QPD_ADDR_BITS) begin
              // Prefix and straps must match or the frame is ignored.
              s_d.st = (sh[7:0] == {QPD_TYPE_PREFIX, strap_hi_s, strap_lo_s}) ?
                       QPD_CMD : QPD_SKIP;
            end else if (s_d.cnt == QPD_CMD_BITS) begin
              op = sh[7:4];
              rs = sh[3:2];
              ch = sh[1:0];
              s_d.tx = 8'h00;
              case (op)
                QPD_OP_RD_WIPER: s_d.tx = s_q.wiper[ch];
                QPD_OP_RD_SLOT: s_d.tx = s_q.slot[ch][rs];
                QPD_OP_STATUS: s_d.tx = {7'h00, s_q.busy};
                QPD_OP_GRECALL: begin
                  for (int c = 0; c < 4; c++) begin
                    s_d.wiper[c] = s_q.slot[c][rs];
                  end
                end
                QPD_OP_RECALL: s_d.wiper[ch] = s_q.slot[ch][rs];
                QPD_OP_STORE: begin
                  s_d.nv_kind = 2'(QPD_NV_ONE);
                  s_d.nv_data = s_q.wiper[ch];
                end
                QPD_OP_GSTORE: s_d.nv_kind = 2'(QPD_NV_ALL);
                default: begin
                end
              endcase
              s_d.nv_ch = ch;
              s_d.nv_slot = rs;
              if (op == QPD_OP_STEP) begin
                s_d.st = QPD_STEP;
              end else if (has_data(op)) begin
                s_d.st = QPD_DATA;
              end else begin
                s_d.st = QPD_SKIP;
              end
              // A store armed by this command byte must still survive to frame end.
              if (op == QPD_OP_STORE || op == QPD_OP_GSTORE) begin
                s_d.st = QPD_SKIP;
              end
            end else if (s_d.cnt == QPD_DATA_BITS) begin
              // The opcode byte sits one byte higher once the last data bit is in.
              op = sh[15:12];
              ch = sh[9:8];
              rs = sh[11:10];
              if (op == QPD_OP_WR_WIPER) begin
                s_d.wiper[ch] = sh[7:0];
              end else if (op == QPD_OP_WR_SLOT) begin
                s_d.nv_kind = 2'(QPD_NV_ONE);
                s_d.nv_data = sh[7:0];
              end
              s_d.st = QPD_SKIP;
            end
          end
          // Read data leaves MSB first, changing on SCK fall.
          if (fall && s_q.st == QPD_DATA && s_q.cnt >= QPD_CMD_BITS) begin
            s_d.so_oe = 1'b1;
            s_d.so = s_q.tx[7];
            s_d.tx = {s_q.tx[6:0], 1'b0};
          end
        end
        QPD_STEP: begin
          if (rise) begin
            if (si_s && s_q.wiper[s_q.nv_ch] != QPD_WIPER_MAX) begin
              s_d.wiper[s_q.nv_ch] = s_q.wiper[s_q.nv_ch] + 8'h01;
            end else if (!si_s && s_q.wiper[s_q.nv_ch] != QPD_WIPER_MIN) begin
              s_d.wiper[s_q.nv_ch] = s_q.wiper[s_q.nv_ch] - 8'h01;
            end
          end
        end
        QPD_SKIP: begin
          s_d.so_oe = 1'b0;
        end
        default: s_d.st = QPD_IDLE;
      endcase
    end
  end

  // All decoder state updates together under the clock enable.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s_q <= '0;
      s_q.st <= QPD_IDLE;
      s_q.sck_prev <= 1'b1; // Matches the parked synchroniser, so no false rise follows reset.
      s_q.wiper <= {4{QPD_WIPER_RST}};
      s_q.slot <= {16{QPD_SLOT_RST}};
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign so = s_q.so;
  assign so_oe = s_q.so_oe;
  assign nv_write_pending_flag = s_q.busy;
  assign wiper_position_reg = s_q.wiper;

  // Checks on the frame engine.
  nv_after_frame_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(s_q.busy) |-> $past(cs_s))
    else $error("nonvolatile cycle began inside a frame");
  abandon_keeps_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (clk_en && cs_s && s_q.st inside {QPD_ADDR, QPD_CMD, QPD_DATA}) |=> $stable(s_q.wiper))
    else $error("abandoned frame changed a wiper");
  mismatch_skip_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (s_q.st == QPD_SKIP && $past(s_q.st) == QPD_ADDR) |-> s_q.shreg[7:2] != QPD_TYPE_PREFIX
      || s_q.shreg[1:0] != {strap_hi_s, strap_lo_s})
    else $error("matching address byte was skipped");
  status_bit_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (s_q.st == QPD_DATA && $past(s_q.st) == QPD_CMD && s_q.shreg[7:0] == {QPD_OP_STATUS,
      QPD_STATUS_LOW}) |-> s_q.tx == {7'h00, $past(s_q.busy)})
    else $error("status byte wrong");
  step_up_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (clk_en && !cs_s && s_q.st == QPD_STEP && rise && si_s &&
      s_q.wiper[s_q.nv_ch] != QPD_WIPER_MAX) |=> s_q.wiper[s_q.nv_ch] == $past(
      s_q.wiper[s_q.nv_ch]) + 8'h01)
    else $error("step up did not move wiper");
  busy_pins_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_q.busy |-> ##1 (s_q.busy || s_q.nv_cnt == 32'(NV_WRITE_CYC - 1)))
    else $error("write flag dropped early");
  so_quiet_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (clk_en && cs_s) |=> !s_q.so_oe)
    else $error("output driven outside frame");
  flag_out_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (clk_en && s_q.busy && s_q.nv_cnt != 32'(NV_WRITE_CYC - 1)) |=> s_q.busy)
    else $error("write flag dropped before the write ended");
  step_cov: cover property (@(posedge core_clk) s_q.st == QPD_STEP ##1 rise);
  nv_cov: cover property (@(posedge core_clk) $rose(s_q.busy));
  read_cov: cover property (@(posedge core_clk) $rose(s_q.so_oe));
endmodule
`default_nettype wire

// ==== test/qpd_spi_master.sv ====
// Serial bus master model that drives command frames into the decoder.
`timescale 1ns/1ps
`default_nettype none
module qpd_spi_master (
  input wire logic core_clk,
  output logic sck,
  output logic cs_n,
  output logic si,
  input wire logic so
);
  // The serial clock stands still low between frames, as a real master leaves it.
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end

  // Half a 48 ns serial period is six core cycles; changes land just after a core edge.
  task automatic half();
    repeat (6) @(posedge core_clk);
    #1;
  endtask

  // Sends the top n bits of b, most significant first, and samples so on each rise.
  task automatic xfer(input logic [39:0] b, input int n, output logic [7:0] rd);
    cs_n = 1'b0;
    half();
    for (int i = 39; i >= 40 - n; i--) begin
      si = b[i];
      half();
      sck = 1'b1;
      rd = {rd[6:0], so};
      half();
      sck = 1'b0;
    end
    // Released data line shows the inverse so a stale level is never mistaken for data.
    si = ~si;
    half();
    cs_n = 1'b1;
    half();
    half();
  endtask
endmodule
`default_nettype wire

// ==== test/tb.sv ====
// Self-checking bench for the quad potentiometer serial command decoder.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import qpd_pkg::*;
  // A short write time keeps the run brief but still outlasts one status frame.
  localparam int NV_CYC = 400;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic strap_hi = 1'b1;
  logic strap_lo = 1'b0;
  logic sck;
  logic cs_n;
  logic si;
  logic so;
  logic so_oe;
  logic so_line;
  logic nv_write_pending_flag;
  logic [31:0] wiper_position_reg;
  logic [7:0] rd;
  logic [7:0] adr;
  int errors = 0;
  int samples_checked = 0;

  // Core clock of 4 ns.
  always #2 core_clk = ~core_clk;

  qpd_decoder #(.NV_WRITE_CYC(NV_CYC)) uut (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .sck(sck),
    .cs_n(cs_n),
    .si(si),
    .strap_addr_hi(strap_hi),
    .strap_addr_lo(strap_lo),
    .so(so),
    .so_oe(so_oe),
    .nv_write_pending_flag(nv_write_pending_flag),
    .wiper_position_reg(wiper_position_reg)
  );

  // An undriven output line shows the inverse of its last level, so only driven bits read true.
  assign so_line = so_oe ? so : ~so;

  qpd_spi_master m (
    .core_clk(core_clk),
    .sck(sck),
    .cs_n(cs_n),
    .si(si),
    .so(so_line)
  );

  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Waits out a nonvolatile write with some margin.
  task automatic nv_wait();
    repeat (NV_CYC + 20) @(posedge core_clk);
  endtask

  // Reads one byte with a three-byte frame.
  task automatic rd_byte(input logic [7:0] op, input logic [7:0] exp);
    m.xfer({adr, op, 24'h0}, 24, rd);
    chk(rd, exp);
  endtask

  // Main sequence of frames and expected results.
  initial begin
    adr = {QPD_TYPE_PREFIX, 2'b10};
    repeat (8) @(posedge core_clk);
    #1;
    sys_rst = 1'b0;
    repeat (4) @(posedge core_clk);
    chk(wiper_position_reg, 32'h80808080);
    m.xfer({adr, QPD_OP_WR_WIPER, 4'h2, 8'h5a, 16'h0}, 24, rd);
    chk(wiper_position_reg, 32'h805a8080);
    rd_byte({QPD_OP_RD_WIPER, 4'h2}, 8'h5a);
    fork
      m.xfer({adr, QPD_OP_WR_SLOT, 4'h7, 8'hc3, 16'h0}, 24, rd);
      begin
        // Looks just before chip select rises, after the last bit has long been taken.
        repeat (24) @(posedge sck);
        repeat (10) @(posedge core_clk);
        #1;
        chk(nv_write_pending_flag, 1'b0);
      end
    join
    chk(nv_write_pending_flag, 1'b1);
    rd_byte({QPD_OP_STATUS, QPD_STATUS_LOW}, 8'h01);
    chk(so_oe, 1'b0);
    nv_wait();
    rd_byte({QPD_OP_STATUS, QPD_STATUS_LOW}, 8'h00);
    rd_byte({QPD_OP_RD_SLOT, 4'h7}, 8'hc3);
    m.xfer({adr, QPD_OP_RECALL, 4'h7, 24'h0}, 16, rd);
    chk(wiper_position_reg, 32'hc35a8080);
    chk(nv_write_pending_flag, 1'b0);
    m.xfer({adr, QPD_OP_STORE, 4'ha, 24'h0}, 16, rd);
    chk(nv_write_pending_flag, 1'b1);
    // A low clock enable freezes the write timer, so the flag outlasts its normal span.
    clk_en = 1'b0;
    repeat (NV_CYC + 100) @(posedge core_clk);
    #1;
    chk(nv_write_pending_flag, 1'b1);
    clk_en = 1'b1;
    nv_wait();
    rd_byte({QPD_OP_RD_SLOT, 4'ha}, 8'h5a);
    m.xfer({adr, QPD_OP_GSTORE, 4'hc, 24'h0}, 16, rd);
    chk(nv_write_pending_flag, 1'b1);
    nv_wait();
    rd_byte({QPD_OP_RD_SLOT, 4'hd}, 8'h80);
    rd_byte({QPD_OP_RD_SLOT, 4'hf}, 8'hc3);
    m.xfer({adr, QPD_OP_WR_WIPER, 4'h0, 8'h00, 16'h0}, 24, rd);
    m.xfer({adr, QPD_OP_WR_WIPER, 4'h3, 8'h07, 16'h0}, 24, rd);
    m.xfer({adr, QPD_OP_GRECALL, 4'hc, 24'h0}, 16, rd);
    chk(wiper_position_reg, 32'hc35a8080);
    // Three up steps and one down step leave the wiper two above where it was.
    m.xfer({adr, QPD_OP_STEP, 4'h0, 8'he0, 16'h0}, 20, rd);
    chk(wiper_position_reg, 32'hc35a8082);
    // A frame for another strap address must change nothing.
    m.xfer({QPD_TYPE_PREFIX, 2'b01, QPD_OP_WR_WIPER, 4'h1, 8'h55, 16'h0}, 24, rd);
    chk(wiper_position_reg, 32'hc35a8082);
    m.xfer({adr, QPD_OP_WR_WIPER, 4'h1, 8'h55, 16'h0}, 20, rd);
    chk(wiper_position_reg, 32'hc35a8082);
    m.xfer({adr, QPD_OP_WR_WIPER, 4'h1, 8'h11, 16'h0}, 24, rd);
    chk(wiper_position_reg, 32'hc35a1182);
    close_out();
  end

  // Watchdog sized well beyond the expected few thousand cycles of traffic.
  initial begin
    repeat (40000) @(posedge core_clk);
    errors++;
    close_out();
  end
endmodule
`default_nettype wire
